/* inc/bapc_pkg.sv */
package bapc_pkg;
   // Bus and attribute widths.
   localparam int ADDR_W = 32;
   localparam int PC_NUM = 16;
   localparam int PC_W = 4;
   localparam int MID_W = 4;
   localparam int LEN_W = 8;
   localparam int DATA_W = 32;
   // Smallest protectable range is one 32-byte granule.
   localparam int GRAN_LOG2 = 5;
   localparam logic [4:0] GRAN_SZ = 5'h05;
   localparam logic [ADDR_W-1:0] GRAN_BYTES = 32'h0000_0020;
   localparam logic [GRAN_LOG2-1:0] GRAN_ZERO = 5'h00;
   // Context 0 is always permitted by every context mask.
   localparam logic [PC_NUM-1:0] PC0_ALWAYS = 16'h0001;
   // Master whose secure-tagged transfers count as secure.
   localparam logic [MID_W-1:0] TRUSTED_MID = 4'h0;
   // Window of the peripheral group served by the peripheral checker.
   localparam logic [ADDR_W-1:0] PGRP_BASE = 32'h4000_0000;
   localparam logic [4:0] PGRP_SZ = 5'h14;
   // Hard-wired regions of the fixed peripheral structures.
   localparam int N_FIXED = 2;
   localparam logic [ADDR_W-1:0] FIX_BASE [N_FIXED] = '{32'h4000_0000, 32'h4001_0000};
   localparam logic [4:0] FIX_SZ [N_FIXED] = '{5'h0C, 5'h0C};
   // Codes naming the checker that refused a transfer.
   localparam logic [1:0] UNIT_NONE = 2'h0;
   localparam logic [1:0] UNIT_MPM = 2'h1;
   localparam logic [1:0] UNIT_SHM = 2'h2;
   localparam logic [1:0] UNIT_PER = 2'h3;

   // One protection structure.
   typedef struct packed {
      logic [ADDR_W-1:0] base;
      logic [4:0] size_log2;
      logic enabled;
      logic ur, uw, ux, pr, pw, px, ns;
      logic [PC_NUM-1:0] pc_mask;
      logic pc_match;
   } bapc_struct_t;

   // Access attributes of one transfer.
   typedef struct packed {
      logic wr, ex, priv, sec;
      logic [PC_W-1:0] pc;
   } bapc_attr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_CHECK = 3'h2,
      ST_FWD = 3'h4
   } bapc_state_t;
endpackage

/* inc/bapc_chk_if.sv */
`timescale 1ns/1ps
// Granule address and attributes to one checker, verdict back.
interface bapc_chk_if
   import bapc_pkg::*;
();
   logic [ADDR_W-1:0] addr;
   bapc_attr_t attr;
   logic active;
   logic hit;
   logic deny;
   modport unit (input addr, attr, active, output hit, deny);
   modport req (output addr, attr, active, input hit, deny);
endinterface

/* hdl/bapc_region_chk.sv */
`timescale 1ns/1ps
module bapc_region_chk
   import bapc_pkg::*;
#(
   parameter int N = 8,
   parameter bit USE_PC = 1'b1
)
(
   // Granule request and verdict.
   bapc_chk_if.unit chk,
   // Protection structures, index N-1 strongest.
   input bapc_struct_t cfg [N]
);
   logic [N-1:0] hit_v;
   logic [N-1:0] fail_v;
   logic hit_any;
   logic deny_sel;

   // Elaboration guard: an empty structure table cannot serve any request.
   if (N < 1)
   begin
      $error("bapc_region_chk needs at least one structure.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-structure matching and access evaluation.
   generate
      for (genvar i = 0; i < N; i++)
      begin : g_ent
         logic [4:0] sz;
         logic [PC_NUM-1:0] pcm;
         logic pc_ok;
         logic rwx_ok;
         logic sec_ok;
         // Sizes below one granule are widened to it.
         assign sz = (cfg[i].size_log2 < GRAN_SZ) ? GRAN_SZ : cfg[i].size_log2;
         assign pcm = cfg[i].pc_mask | PC0_ALWAYS;
         // The per-master flavour is built with USE_PC cleared and never looks at context.
         assign pc_ok = !USE_PC || pcm[chk.attr.pc];
         assign hit_v[i] = cfg[i].enabled
            && ((chk.addr >> sz) == (cfg[i].base >> sz))
            && (!USE_PC || !cfg[i].pc_match || pc_ok);
         assign rwx_ok = chk.attr.wr ? (chk.attr.priv ? cfg[i].pw : cfg[i].uw)
            : chk.attr.ex ? (chk.attr.priv ? cfg[i].px : cfg[i].ux)
            : (chk.attr.priv ? cfg[i].pr : cfg[i].ur);
         assign sec_ok = cfg[i].ns || chk.attr.sec;
         // Every evaluation must pass; context only counts when not used for matching.
         assign fail_v[i] = !(rwx_ok && sec_ok && (cfg[i].pc_match || pc_ok));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Ascending walk, so the highest matching index has the last word.
   always_comb
   begin
      hit_any = 1'b0;
      deny_sel = 1'b0;
      for (int k = 0; k < N; k++)
      begin
         if (hit_v[k])
         begin
            hit_any = 1'b1;
            deny_sel = fail_v[k];
         end
      end
   end

   // No match means the transfer passes this checker.
   assign chk.hit = chk.active && hit_any;
   assign chk.deny = chk.active && hit_any && deny_sel;
endmodule

/* hdl/bapc_fault_log.sv */
`timescale 1ns/1ps
module bapc_fault_log
   import bapc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Violation event.
   input wire logic evt,
   input wire logic [ADDR_W-1:0] evt_addr,
   input bapc_attr_t evt_attr,
   input wire logic [MID_W-1:0] evt_mid,
   input wire logic [1:0] evt_unit,
   input wire logic evt_buf,
   // Software side.
   input wire logic ack,
   input wire logic irq_en,
   // Held record.
   output logic flt_valid,
   output logic [ADDR_W-1:0] flt_addr,
   output bapc_attr_t flt_attr,
   output logic [MID_W-1:0] flt_mid,
   output logic [1:0] flt_unit,
   output logic flt_buf,
   output logic flt_overflow,
   output logic flt_irq
);
   logic valid_ff, ovf_ff, irq_ff, buf_ff;
   logic [ADDR_W-1:0] addr_ff;
   bapc_attr_t attr_ff;
   logic [MID_W-1:0] mid_ff;
   logic [1:0] unit_ff;
   logic nxt_valid, take;

   // A new fault is taken when the slot is free or being freed; set beats clear.
   assign take = evt && (!valid_ff || ack);
   assign nxt_valid = evt || (valid_ff && !ack);

   ////////////////////////////////////////////////////////////////////////
   // Record, held until acknowledged.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         valid_ff <= 1'b0;
         addr_ff <= '0;
         attr_ff <= '0;
         mid_ff <= '0;
         unit_ff <= UNIT_NONE;
         buf_ff <= 1'b0;
      end
      else
      begin
         valid_ff <= nxt_valid;
         if (take)
         begin
            addr_ff <= evt_addr;
            attr_ff <= evt_attr;
            mid_ff <= evt_mid;
            unit_ff <= evt_unit;
            buf_ff <= evt_buf;
         end
      end
   end

   // A second fault while one is held is only counted as lost.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         ovf_ff <= 1'b0;
      else
         ovf_ff <= (evt && valid_ff && !ack) || (ovf_ff && !ack);
   end

   // Interrupt lets another CPU service the fault.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         irq_ff <= 1'b0;
      else
         irq_ff <= nxt_valid && irq_en;
   end

   assign flt_valid = valid_ff;
   assign flt_addr = addr_ff;
   assign flt_attr = attr_ff;
   assign flt_mid = mid_ff;
   assign flt_unit = unit_ff;
   assign flt_buf = buf_ff;
   assign flt_overflow = ovf_ff;
   assign flt_irq = irq_ff;

   a_fault_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      valid_ff && !ack |=> valid_ff && $stable(addr_ff) && $stable(attr_ff))
      else $error("Fault record changed before acknowledge.");
   a_fault_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
      evt && irq_en |=> irq_ff)
      else $error("Logged fault raised no interrupt.");
endmodule

/* hdl/bapc_top.sv */
`timescale 1ns/1ps
module bapc_top
   import bapc_pkg::*;
#(
   parameter int N_MPM = 8,
   parameter int N_SHM = 16,
   parameter int N_PPROG = 8
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Master request.
   input wire logic m_valid,
   output logic m_ready,
   input wire logic [ADDR_W-1:0] m_addr,
   input wire logic [LEN_W-1:0] m_len,
   input wire logic m_write,
   input wire logic m_exec,
   input wire logic m_priv,
   input wire logic m_sec_tag,
   input wire logic [PC_W-1:0] m_pc,
   input wire logic [MID_W-1:0] m_mid,
   input wire logic [DATA_W-1:0] m_wdata,
   // Master response.
   output logic m_resp_valid,
   output logic m_resp_err,
   output logic [DATA_W-1:0] m_rdata,
   // Target side.
   output logic t_valid,
   input wire logic t_ack,
   output logic [ADDR_W-1:0] t_addr,
   output logic [LEN_W-1:0] t_len,
   output logic t_write,
   output logic [DATA_W-1:0] t_wdata,
   input wire logic [DATA_W-1:0] t_rdata,
   // Protection configuration.
   input wire logic write_buffering_enable,
   input bapc_struct_t cfg_mpm [N_MPM],
   input bapc_struct_t cfg_shm [N_SHM],
   input bapc_struct_t cfg_pfix [N_FIXED],
   input bapc_struct_t cfg_pprog [N_PPROG],
   // Fault record.
   input wire logic fault_ack,
   input wire logic fault_irq_en,
   output logic fault_valid,
   output logic [ADDR_W-1:0] fault_addr,
   output bapc_attr_t fault_attr,
   output logic [MID_W-1:0] fault_mid,
   output logic [1:0] fault_unit,
   output logic fault_buffered,
   output logic fault_overflow,
   output logic fault_irq
);
   localparam int N_PER = N_FIXED + N_PPROG;
   localparam int GL_W = LEN_W - GRAN_LOG2 + 1;

   bapc_state_t st_ff;
   logic [ADDR_W-1:0] addr_ff, gaddr_ff;
   logic [LEN_W-1:0] len_ff;
   logic [GL_W-1:0] gleft_ff;
   bapc_attr_t attr_ff, req_attr;
   logic [MID_W-1:0] mid_ff;
   logic [DATA_W-1:0] wdata_ff, rdata_ff;
   logic buf_ff, resp_valid_ff, resp_err_ff;
   logic accept, in_group, now_deny, last_gran;
   logic [1:0] deny_unit;
   logic [LEN_W:0] span;
   bapc_struct_t cfg_per [N_PER];

   bapc_chk_if mpm_if ();
   bapc_chk_if shm_if ();
   bapc_chk_if per_if ();

   // Elaboration guard: the walker needs length bits above the granule, every checker an entry.
   if (LEN_W <= GRAN_LOG2 || N_MPM < 1 || N_SHM < 1 || N_PPROG < 1)
   begin
      $error("bapc_top: walker or checker parameters out of range.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Request capture.

   assign accept = m_valid && m_ready;
   // Zero length is treated as one byte.
   assign span = {1'b0, m_len} + {{(LEN_W-GRAN_LOG2+1){1'b0}}, m_addr[GRAN_LOG2-1:0]}
      - ((m_len == '0) ? '0 : {{LEN_W{1'b0}}, 1'b1});
   // Only the trusted CPU may claim secure; one assignment keeps the struct single-driven.
   assign req_attr = {m_write, m_exec, m_priv,
      m_sec_tag && (m_mid == TRUSTED_MID), m_pc};

   // Transfer fields held for the whole check and forward.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         addr_ff <= '0;
         len_ff <= '0;
         attr_ff <= '0;
         mid_ff <= '0;
         wdata_ff <= '0;
         buf_ff <= 1'b0;
      end
      else if (accept)
      begin
         addr_ff <= m_addr;
         len_ff <= m_len;
         attr_ff <= req_attr;
         mid_ff <= m_mid;
         wdata_ff <= m_wdata;
         buf_ff <= m_write && write_buffering_enable;
      end
   end

   // Granule walker: first granule on accept, then one step per check cycle.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         gaddr_ff <= '0;
         gleft_ff <= '0;
      end
      else if (accept)
      begin
         gaddr_ff <= {m_addr[ADDR_W-1:GRAN_LOG2], GRAN_ZERO};
         gleft_ff <= span[LEN_W:GRAN_LOG2];
      end
      else if (st_ff == ST_CHECK && !last_gran)
      begin
         gaddr_ff <= gaddr_ff + GRAN_BYTES;
         gleft_ff <= gleft_ff - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checkers.

   // Lower peripheral entries are fixed regions; software sets only their attributes.
   always_comb
   begin
      for (int k = 0; k < N_FIXED; k++)
      begin
         cfg_per[k] = cfg_pfix[k];
         cfg_per[k].base = FIX_BASE[k];
         cfg_per[k].size_log2 = FIX_SZ[k];
      end
      for (int k = 0; k < N_PPROG; k++)
         cfg_per[N_FIXED+k] = cfg_pprog[k];
   end

   assign in_group = (gaddr_ff >> PGRP_SZ) == (PGRP_BASE >> PGRP_SZ);
   assign mpm_if.addr = gaddr_ff;
   assign mpm_if.attr = attr_ff;
   assign mpm_if.active = (st_ff == ST_CHECK);
   assign shm_if.addr = gaddr_ff;
   assign shm_if.attr = attr_ff;
   assign shm_if.active = (st_ff == ST_CHECK);
   assign per_if.addr = gaddr_ff;
   assign per_if.attr = attr_ff;
   // Peripheral check runs only inside the group and after memory checks pass.
   assign per_if.active = (st_ff == ST_CHECK) && in_group
      && !mpm_if.deny && !shm_if.deny;

   bapc_region_chk #(.N(N_MPM), .USE_PC(1'b0)) u_per_master_memory_checker (
      .chk(mpm_if.unit),
      .cfg(cfg_mpm)
   );
   bapc_region_chk #(.N(N_SHM), .USE_PC(1'b1)) u_shared_memory_checker (
      .chk(shm_if.unit),
      .cfg(cfg_shm)
   );
   bapc_region_chk #(.N(N_PER), .USE_PC(1'b1)) u_peripheral_access_checker (
      .chk(per_if.unit),
      .cfg(cfg_per)
   );

   // Blame goes to the first level that refused.
   assign now_deny = mpm_if.deny || shm_if.deny || per_if.deny;
   assign deny_unit = mpm_if.deny ? UNIT_MPM : shm_if.deny ? UNIT_SHM : UNIT_PER;
   assign last_gran = (gleft_ff == '0);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: idle, one check cycle per granule, forward.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         st_ff <= ST_IDLE;
      else
      begin
         case (st_ff)
            ST_IDLE:
               if (m_valid)
                  st_ff <= ST_CHECK;
            ST_CHECK:
               if (now_deny)
                  st_ff <= ST_IDLE;
               else if (last_gran)
                  st_ff <= ST_FWD;
            ST_FWD:
               if (t_ack)
                  st_ff <= ST_IDLE;
            default:
               st_ff <= ST_IDLE;
         endcase
      end
   end

   // Response: early ack for buffered writes, error or completion otherwise.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         resp_valid_ff <= 1'b0;
         resp_err_ff <= 1'b0;
      end
      else
      begin
         resp_valid_ff <= (accept && m_write && write_buffering_enable)
            || (st_ff == ST_CHECK && now_deny && !buf_ff)
            || (st_ff == ST_FWD && t_ack && !buf_ff);
         // A buffered write was already acknowledged, so it cannot see an error.
         resp_err_ff <= st_ff == ST_CHECK && now_deny && !buf_ff;
      end
   end

   // Read data captured from the target.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rdata_ff <= '0;
      else if (st_ff == ST_FWD && t_ack)
         rdata_ff <= t_rdata;
   end

   assign m_ready = (st_ff == ST_IDLE);
   assign m_resp_valid = resp_valid_ff;
   assign m_resp_err = resp_err_ff;
   assign m_rdata = rdata_ff;
   // Target sees only transfers that passed every granule.
   assign t_valid = (st_ff == ST_FWD);
   assign t_addr = addr_ff;
   assign t_len = len_ff;
   assign t_write = attr_ff.wr;
   assign t_wdata = wdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Fault record, fed by buffered and unbuffered violations alike.
   bapc_fault_log u_fault_log (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .evt(st_ff == ST_CHECK && now_deny),
      .evt_addr(addr_ff),
      .evt_attr(attr_ff),
      .evt_mid(mid_ff),
      .evt_unit(deny_unit),
      .evt_buf(buf_ff),
      .ack(fault_ack),
      .irq_en(fault_irq_en),
      .flt_valid(fault_valid),
      .flt_addr(fault_addr),
      .flt_attr(fault_attr),
      .flt_mid(fault_mid),
      .flt_unit(fault_unit),
      .flt_buf(fault_buffered),
      .flt_overflow(fault_overflow),
      .flt_irq(fault_irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_deny_err_resp: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff == ST_CHECK && now_deny && !buf_ff |=> m_resp_valid && m_resp_err && !t_valid)
      else $error("Violation not answered with bus error.");
   a_deny_no_fwd: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff == ST_CHECK && now_deny |=> !t_valid [*2])
      else $error("Violating transfer reached the target.");
   a_buf_early_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
      accept && m_write && write_buffering_enable |=> m_resp_valid && !m_resp_err)
      else $error("Buffered write not acknowledged at once.");
   a_buf_no_err: assert property (@(posedge clk_sys) disable iff (!nrst)
      m_resp_err |-> !buf_ff)
      else $error("Buffered write answered with bus error.");
   a_fault_logged: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff == ST_CHECK && now_deny |=> fault_valid)
      else $error("Violation not recorded.");
   a_gran_step: assert property (@(posedge clk_sys) disable iff (!nrst)
      st_ff == ST_CHECK && !now_deny && !last_gran
      |=> st_ff == ST_CHECK && gaddr_ff == $past(gaddr_ff) + GRAN_BYTES)
      else $error("Granule walk skipped a region.");
   a_per_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
      (mpm_if.deny || shm_if.deny) |-> !per_if.active)
      else $error("Memory-level failure reached peripheral check.");
   a_per_scope: assert property (@(posedge clk_sys) disable iff (!nrst)
      per_if.deny |-> in_group && deny_unit == UNIT_PER)
      else $error("Peripheral checker acted outside its group.");
endmodule

/* sim/bapc_target_model.sv */
`timescale 1ns/1ps
// Target that answers after zero or three waits and counts the accesses it completes.
module bapc_target_model
   import bapc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Target bus.
   input wire logic t_valid,
   output logic t_ack,
   input wire logic [ADDR_W-1:0] t_addr,
   input wire logic t_write,
   input wire logic [DATA_W-1:0] t_wdata,
   output logic [DATA_W-1:0] t_rdata,
   // Bench control and observation.
   input wire logic slow,
   output int n_acc,
   output logic [DATA_W-1:0] last_wdata
);
   int wait_cnt;
   ////////////////////////////////////////
   // Read data is only good beside the ack; it flips otherwise so stale data never matches.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         t_ack <= 1'b0;
         t_rdata <= 32'h0;
         wait_cnt <= 0;
         n_acc <= 0;
         last_wdata <= 32'h0;
      end
      else if (t_valid && !t_ack && wait_cnt >= (slow ? 3 : 0))
      begin
         t_ack <= 1'b1;
         t_rdata <= t_addr ^ 32'hA5A5_0000;
         wait_cnt <= 0;
         n_acc <= n_acc + 1;
         if (t_write)
            last_wdata <= t_wdata;
      end
      else
      begin
         t_ack <= 1'b0;
         t_rdata <= ~t_rdata;
         wait_cnt <= (t_valid && !t_ack) ? wait_cnt + 1 : 0;
      end
   end
endmodule

/* sim/bapc_test.sv */
`timescale 1ns/1ps
module bapc_test;
   import bapc_pkg::*;
   // One table row: address, kind {wr,ex,priv,sec}, context, master, result {err,unit}.
   typedef struct packed {
      logic [31:0] addr;
      logic [3:0] kind;
      logic [3:0] pc;
      logic [3:0] mid;
      logic [2:0] res;
   } bapc_row_t;
   logic clk_sys, nrst, m_valid, m_ready, m_write, m_exec, m_priv, m_sec_tag;
   logic [31:0] m_addr, m_wdata, m_rdata, t_addr, t_wdata, t_rdata, fault_addr, last_wdata;
   logic [7:0] m_len, t_len;
   logic [11:0] exp_rec;
   logic [3:0] m_pc, m_mid, fault_mid;
   logic m_resp_valid, m_resp_err, t_valid, t_ack, t_write, write_buffering_enable;
   logic fault_ack, fault_irq_en, fault_valid, fault_buffered, fault_overflow, fault_irq, slow;
   logic [1:0] fault_unit;
   bapc_attr_t fault_attr;
   bapc_struct_t cfg_mpm [3];
   bapc_struct_t cfg_shm [3];
   bapc_struct_t cfg_pfix [N_FIXED];
   bapc_struct_t cfg_pprog [2];
   int n_acc, n_errors, cmp_count, cycles, acc0, lat;
   logic err;
   bapc_row_t rows [15] = '{
      '{32'h1000_0000, 4'h0, 4'h5, 4'h0, 3'h0},
      '{32'h1000_0000, 4'h8, 4'h0, 4'h0, 3'h5},
      '{32'h1000_0100, 4'h2, 4'h0, 4'h0, 3'h5},
      '{32'h2000_0000, 4'h0, 4'h2, 4'h0, 3'h0},
      '{32'h2000_0000, 4'h0, 4'h1, 4'h0, 3'h6},
      '{32'h3000_0000, 4'h3, 4'h0, 4'h0, 3'h0},
      '{32'h3000_0000, 4'h3, 4'h0, 4'h1, 3'h6},
      '{32'h4000_0000, 4'h0, 4'h0, 4'h0, 3'h7},
      '{32'h4000_0000, 4'h2, 4'h0, 4'h0, 3'h0},
      '{32'h4002_0000, 4'h0, 4'h0, 4'h0, 3'h7},
      '{32'h4002_0000, 4'h6, 4'h0, 4'h0, 3'h6},
      '{32'h5000_0000, 4'h0, 4'h0, 4'h0, 3'h0},
      '{32'h6000_0000, 4'h8, 4'h0, 4'h0, 3'h0},
      '{32'h4003_0000, 4'h2, 4'h1, 4'h0, 3'h7},
      '{32'h4003_0000, 4'h2, 4'h3, 4'h0, 3'h0}};

   bapc_top #(.N_MPM(3), .N_SHM(3), .N_PPROG(2)) dut (.*);
   bapc_target_model u_tgt (.*);

   ////////////////////////////////////////
   // Enabled structure from base, size, {ur,uw,ux,pr,pw,px,ns}, context mask and match flag.
   function automatic bapc_struct_t mk(input logic [31:0] b, input logic [4:0] s,
      input logic [6:0] p, input logic [15:0] m, input logic x);
      return bapc_struct_t'({b, s, 1'b1, p, m, x});
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Waits for idle, issues one request and times its response in edges after acceptance.
   task automatic xfer(input logic [31:0] a, input logic [7:0] len, input logic [3:0] k,
      input logic [3:0] pc, input logic [3:0] mid);
      for (int i = 0; i < 40 && m_ready !== 1'b1; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      {m_write, m_exec, m_priv, m_sec_tag} = k;
      {m_addr, m_len, m_pc, m_mid, m_wdata} = {a, len, pc, mid, a ^ 32'h0F0F_0000};
      m_valid = 1'b1;
      acc0 = n_acc;
      @(posedge clk_sys);
      #1;
      m_valid = 1'b0;
      // The buffered early answer stands only in the first cycle after acceptance.
      for (lat = 1; lat < 40 && m_resp_valid !== 1'b1; lat++)
      begin
         @(posedge clk_sys);
         #1;
      end
      err = m_resp_err;
      check(m_resp_valid, 1'b1, "response seen");
   endtask

   task automatic ack_fault();
      fault_ack = 1'b1;
      @(posedge clk_sys);
      #1;
      fault_ack = 1'b0;
   endtask

   ////////////////////////////////////////
   // Clock, and a ceiling far above the roughly 110 cycles the run needs.
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   // Disabled structure 2 would refuse everything in its range, so any hit on it shows.
   initial
   begin
      {nrst, m_valid, m_addr, m_len, m_write, m_exec, m_priv, m_sec_tag} = '0;
      {m_pc, m_mid, m_wdata, write_buffering_enable, fault_ack, slow} = '0;
      fault_irq_en = 1'b1;
      cfg_mpm = '{mk(32'h1000_0000, 5'h0C, 7'h00, 16'h0001, 1'b0),
         mk(32'h1000_0000, 5'h08, 7'h4D, 16'h0001, 1'b0),
         mk(32'h1000_0000, 5'h08, 7'h00, 16'h0001, 1'b0)};
      cfg_mpm[2].enabled = 1'b0;
      cfg_shm = '{mk(32'h2000_0000, 5'h08, 7'h7F, 16'h0004, 1'b0),
         mk(32'h3000_0000, 5'h08, 7'h7E, 16'hFFFF, 1'b0),
         mk(32'h4002_0000, 5'h08, 7'h6D, 16'hFFFF, 1'b0)};
      cfg_pfix = '{mk(32'h5000_0000, 5'h08, 7'h0D, 16'hFFFF, 1'b0),
         mk(32'h5000_0000, 5'h08, 7'h7F, 16'hFFFF, 1'b0)};
      cfg_pprog = '{mk(32'h4002_0000, 5'h08, 7'h0D, 16'hFFFF, 1'b0),
         mk(32'h4003_0000, 5'h08, 7'h00, 16'h0002, 1'b1)};
      repeat (16) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      check(m_ready, 1'b1, "ready after reset");
      check({t_valid, m_resp_valid, fault_valid, fault_irq}, 4'h0, "reset outputs");
      foreach (rows[i])
      begin
         slow = i[0];
         xfer(rows[i].addr, 8'h04, rows[i].kind, rows[i].pc, rows[i].mid);
         check(err, rows[i].res[2], "response error");
         check(fault_valid, rows[i].res[2], "fault flag");
         check(n_acc - acc0, !rows[i].res[2], "target accesses");
         if (rows[i].res[2])
         begin
            check(lat, 2, "deny latency");
            check(fault_unit, rows[i].res[1:0], "fault unit");
            check(fault_addr, rows[i].addr, "fault record");
            exp_rec = {rows[i].mid, rows[i].kind[3:1], rows[i].kind[0], rows[i].pc};
            exp_rec[4] = exp_rec[4] && (rows[i].mid == TRUSTED_MID);
            check({fault_mid, fault_attr}, exp_rec, "fault attributes");
            ack_fault();
         end
         else if (!rows[i].kind[3])
            check(m_rdata, rows[i].addr ^ 32'hA5A5_0000, "read data");
      end
      ////////////////////////////////////////
      // Second granule refused; the record then holds against a later violation.
      xfer(32'h1000_00F0, 8'h20, 4'h2, 4'h0, 4'h0);
      check({err, lat[3:0]}, 5'h13, "two granule deny");
      xfer(32'h1000_0100, 8'h01, 4'h2, 4'h0, 4'h0);
      check(fault_addr, 32'h1000_00F0, "record held");
      check({fault_overflow, fault_irq}, 2'h3, "overflow and irq");
      ack_fault();
      check({fault_valid, fault_overflow}, 2'h0, "cleared by ack");
      fault_irq_en = 1'b0;
      xfer(32'h1000_0100, 8'h01, 4'h2, 4'h0, 4'h0);
      @(posedge clk_sys);
      #1;
      check({fault_valid, fault_irq}, 2'h2, "irq masked");
      ack_fault();
      // Buffered writes: early response, refusal only logged, allowed data still lands.
      write_buffering_enable = 1'b1;
      xfer(32'h1000_0100, 8'h04, 4'hA, 4'h0, 4'h0);
      check({err, lat[3:0]}, 5'h01, "buffered early ok");
      @(posedge clk_sys);
      #1;
      check({fault_valid, fault_buffered, fault_unit}, 4'hD, "buffered fault");
      repeat (4) @(posedge clk_sys);
      #1;
      check(n_acc - acc0, 0, "blocked buffered write");
      ack_fault();
      xfer(32'h6000_0000, 8'h04, 4'hA, 4'h0, 4'h0);
      check({err, lat[3:0]}, 5'h01, "buffered allowed");
      xfer(32'h6000_0000, 8'h04, 4'h2, 4'h0, 4'h0);
      check(last_wdata, 32'h6F0F_0000, "buffered data landed");
      write_buffering_enable = 1'b0;
      // Mid-run reset drops a held fault; a request at the first edge after release completes.
      fault_irq_en = 1'b1;
      xfer(32'h1000_0100, 8'h01, 4'h2, 4'h0, 4'h0);
      check(fault_irq, 1'b1, "irq before reset");
      nrst = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      check({fault_valid, fault_irq, t_valid, m_resp_valid, m_ready}, 5'h01, "reset again");
      xfer(32'h1000_0000, 8'h04, 4'h2, 4'h0, 4'h0);
      check({err, lat[3:0]}, 5'h04, "read after reset");
      check(m_rdata, 32'hB5A5_0000, "read data after reset");
      check(t_len, 8'h04, "target length");
      report_and_stop();
   end
endmodule
